/* verilog/sram_pins_pkg.sv */
/*
 * Shared constants for the split-port burst SRAM pin model: organisation
 * widths, burst shape and read pipeline positions.
 * Assumes the model samples the input clock pair with its own system clock.
 */
`default_nettype none
package sram_pins_pkg;
    // Organisation widths: data, mask count and address per part width
    localparam int DATA_W_X8  = 8;
    localparam int DATA_W_X9  = 9;
    localparam int DATA_W_X18 = 18;
    localparam int DATA_W_X36 = 36;
    localparam int MASK_W_X8  = 2;   // Nibble masks
    localparam int MASK_W_X9  = 1;
    localparam int MASK_W_X18 = 2;
    localparam int MASK_W_X36 = 4;
    localparam int ADDR_W_X8  = 21;
    localparam int ADDR_W_X9  = 21;
    localparam int ADDR_W_X18 = 20;
    localparam int ADDR_W_X36 = 19;

    // Burst shape
    localparam int BURST_LEN = 4;
    localparam int BEAT_W    = 2;
    localparam logic [1:0] BEAT_FIRST = 2'h0;
    localparam logic [1:0] BEAT_LAST  = 2'h3;

    // Read pipeline, counted in input clock edges (either phase)
    localparam int PIPE_LEN      = 8;
    localparam int RD_FIRST_POS  = 4;   // First beat launched on the fifth edge
    localparam int RD_BLOCK_POS  = 1;   // A read one K cycle back blocks a new one

    // Synchroniser depth for pin inputs
    localparam int SYNC_STAGES = 2;

    // Stored array depth (address bits kept), a modelling choice
    localparam int ARRAY_AW_DEF = 8;

    // Write engine states
    typedef enum logic [0:0] {
        WR_IDLE  = 1'b0,
        WR_BURST = 1'b1
    } wr_state_e;
endpackage
`default_nettype wire

/* verilog/ddr_split_port_sram_pins.sv */
/*
 * Pin-level model of a split-port double-data-rate burst SRAM: write port,
 * read port with 2.5 cycle latency, masks, valid indicator and echo clocks.
 * Assumes clk is much faster than the input clock pair; every pin input is
 * synchronised into clk and input clock edges are found by sampling.
 * Only the low ARRAY_AW address bits are stored; higher bits alias.
 */
// How it works
// - Write select low at a K rising edge starts a write.
// - With the write port deselected data inputs are ignored, memory untouched.
// - x8: nibble mask 0 guards bits 3:0, mask 1 guards bits 7:4.
// - Nibble masks sampled with their beat; masked nibble is not written.
// - Byte masks guard 9-bit lanes in order, up to four lanes in x36.
// - Byte masks sampled with their beat; masked byte keeps stored value.
// - One address bus, captured at K rising edge when an access starts.
// - Address is 21, 20 or 19 bits; each address holds four words.
// - Address is ignored for a port that is deselected.
// - Read beats launch on rising edges of both K and K#.
// - Read select low at a K rising edge starts a read.
// - Deselected read port finishes pending burst, then outputs float.
// - Every read returns four sequential words of the location.
// - Valid indicator is high with read data, changing with echo clocks.
// - Accesses start on K rising edges, which also capture and launch.
// - K# rising edges also capture inputs and launch read beats.
// - Echo clock pair runs freely, following K.
// - Write data beats are taken on both K and K# rising edges.
`timescale 1ns/100ps
`default_nettype none
module ddr_split_port_sram_pins
    import sram_pins_pkg::*;
#(
    parameter int DATA_W   = DATA_W_X8,
    parameter int MASK_W   = MASK_W_X8,
    parameter int ADDR_W   = ADDR_W_X8,
    parameter int ARRAY_AW = ARRAY_AW_DEF
) (
    // System clock, enable and reset
    input  wire logic              clk,
    input  wire logic              ce,
    input  wire logic              reset,
    // Input clock pair from the controller
    input  wire logic              k_clk,
    input  wire logic              k_clk_n,
    // Port selects and shared address
    input  wire logic              write_port_select_n,
    input  wire logic              read_port_select_n,
    input  wire logic [ADDR_W-1:0] addr,
    // Write data and masks (nibble or byte masks by organisation)
    input  wire logic [DATA_W-1:0] wr_data,
    input  wire logic [MASK_W-1:0] write_mask_n,
    // Read data, output enable (low while driving) and valid
    output logic      [DATA_W-1:0] rd_data,
    output logic                   rd_data_oe_n,
    output logic                   read_data_valid,
    // Echo clock pair
    output logic                   echo_clock,
    output logic                   echo_clock_n
);
    localparam int LANE_W = DATA_W / MASK_W;
    localparam int MEM_AW = ARRAY_AW + BEAT_W;

    // Synchroniser chains; stage 0 feeds only stage 1
    logic [SYNC_STAGES-1:0] k_sync_q;
    logic [SYNC_STAGES-1:0] kn_sync_q;
    logic [SYNC_STAGES-1:0] wsel_sync_q;
    logic [SYNC_STAGES-1:0] rsel_sync_q;
    logic [ADDR_W-1:0]      addr_s0_q;
    logic [ADDR_W-1:0]      addr_s1_q;
    logic [DATA_W-1:0]      data_s0_q;
    logic [DATA_W-1:0]      data_s1_q;
    logic [MASK_W-1:0]      mask_s0_q;
    logic [MASK_W-1:0]      mask_s1_q;
    logic                   k_last_q;
    logic                   kn_last_q;
    logic                   k_rise;
    logic                   kn_rise;
    logic                   any_edge;

    // Write engine
    wr_state_e              wr_state_q;
    logic [BEAT_W-1:0]      wr_beat_q;
    logic [ADDR_W-1:0]      wr_addr_q;
    logic                   wr_start;
    logic                   wr_take;
    logic [MASK_W-1:0]      lane_we;

    // Read pipeline
    logic [PIPE_LEN-1:0]    pipe_v_q;
    logic [PIPE_LEN-1:0]    pipe_s_q;
    logic [ADDR_W-1:0]      rd_addr_q [2];
    logic                   rd_slot_q;
    logic                   rd_start;
    logic                   rd_hit;
    logic [BEAT_W-1:0]      rd_beat;
    logic                   rd_slot;

    // Storage array
    logic [DATA_W-1:0]      mem [1 << MEM_AW];

    // Two-flop synchronisers for every pin input; address, data and masks
    // take the same delay as the clock pair, so each edge sees its own values
    always_ff @(posedge clk) begin
        if (ce) begin
            k_sync_q    <= {k_sync_q[0], k_clk};
            kn_sync_q   <= {kn_sync_q[0], k_clk_n};
            wsel_sync_q <= {wsel_sync_q[0], write_port_select_n};
            rsel_sync_q <= {rsel_sync_q[0], read_port_select_n};
            addr_s0_q  <= addr;
            addr_s1_q  <= addr_s0_q;
            data_s0_q  <= wr_data;
            data_s1_q  <= data_s0_q;
            mask_s0_q  <= write_mask_n;
            mask_s1_q  <= mask_s0_q;
        end
    end

    // Edge finders on the synchronised clock pair
    always_ff @(posedge clk) begin
        if (reset) begin
            // Track the live level so leaving reset does not fake an edge
            k_last_q  <= k_sync_q[1];
            kn_last_q <= kn_sync_q[1];
        end else if (ce) begin
            k_last_q  <= k_sync_q[1];
            kn_last_q <= kn_sync_q[1];
        end
    end

    assign k_rise   = ce && k_sync_q[1] && !k_last_q;
    assign kn_rise  = ce && kn_sync_q[1] && !kn_last_q;
    assign any_edge = k_rise || kn_rise;

    // Write accepted when idle or on the edge that takes the last beat
    assign wr_start = k_rise && !wsel_sync_q[1]
                      && (wr_state_q == WR_IDLE || wr_beat_q == BEAT_LAST);
    // Even beats on K#, odd beats on K
    assign wr_take  = (wr_state_q == WR_BURST)
                      && ((kn_rise && !wr_beat_q[0]) || (k_rise && wr_beat_q[0]));

    // Write burst sequencer; a select on the last-beat edge wins over the
    // burst end, so writes run back to back
    always_ff @(posedge clk) begin
        if (reset) begin
            wr_state_q <= WR_IDLE;
            wr_beat_q  <= BEAT_FIRST;
            wr_addr_q  <= '0;
        end else begin
            if (wr_take) begin
                wr_beat_q <= wr_beat_q + 1'b1;
            end
            if (wr_start) begin
                wr_state_q <= WR_BURST;
                wr_beat_q  <= BEAT_FIRST;
                wr_addr_q  <= addr_s1_q;
            end else if (wr_take && wr_beat_q == BEAT_LAST) begin
                wr_state_q <= WR_IDLE;
            end
        end
    end

    // Per-lane write enables; a masked lane keeps its stored value
    for (genvar i = 0; i < MASK_W; i++) begin : g_lane
        assign lane_we[i] = wr_take && !mask_s1_q[i];

        a_lane_masked: assert property (@(posedge clk) disable iff (reset)
            (wr_take && mask_s1_q[i]) |-> !lane_we[i])
            else $error("masked lane written");
    end

    // Array write in one process, so the array has a single writer
    always_ff @(posedge clk) begin
        for (int i = 0; i < MASK_W; i++) begin
            if (lane_we[i]) begin
                mem[{wr_addr_q[ARRAY_AW-1:0], wr_beat_q}][i*LANE_W +: LANE_W] <=
                    data_s1_q[i*LANE_W +: LANE_W];
            end
        end
    end

    // Read accept: one K cycle after an accept is still within the burst
    assign rd_start = k_rise && !rsel_sync_q[1] && !pipe_v_q[RD_BLOCK_POS];

    // Read pipeline shifts once per input clock edge
    // Two address slots: a new read lands while the last beat still reads the old slot
    always_ff @(posedge clk) begin
        if (reset) begin
            pipe_v_q     <= '0;
            pipe_s_q     <= '0;
            rd_slot_q    <= 1'b0;
            rd_addr_q[0] <= '0;
            rd_addr_q[1] <= '0;
        end else if (any_edge) begin
            pipe_v_q <= {pipe_v_q[PIPE_LEN-2:0], rd_start};
            pipe_s_q <= {pipe_s_q[PIPE_LEN-2:0], rd_slot_q};
            if (rd_start) begin
                rd_addr_q[rd_slot_q] <= addr_s1_q;
                rd_slot_q            <= !rd_slot_q;
            end
        end
    end

    // Select which beat, if any, launches on this edge
    always_comb begin
        rd_hit  = 1'b0;
        rd_beat = BEAT_FIRST;
        rd_slot = 1'b0;
        for (int j = 0; j < BURST_LEN; j++) begin
            if (pipe_v_q[RD_FIRST_POS + j]) begin
                rd_hit  = 1'b1;
                rd_beat = BEAT_W'(j);
                rd_slot = pipe_s_q[RD_FIRST_POS + j];
            end
        end
    end

    // Output launch on both K and K# edges; float once no beat is due
    // Read data keeps its last value while floated; the drive enable and valid say when it counts
    always_ff @(posedge clk) begin
        if (reset) begin
            rd_data         <= '0;
            rd_data_oe_n    <= 1'b1;
            read_data_valid <= 1'b0;
        end else if (any_edge) begin
            rd_data_oe_n    <= !rd_hit;
            read_data_valid <= rd_hit;
            if (rd_hit) begin
                rd_data <= mem[{rd_addr_q[rd_slot][ARRAY_AW-1:0], rd_beat}];
            end
        end
    end

    // Echo clocks follow K while ce is high, in step with the valid flop
    always_ff @(posedge clk) begin
        if (reset) begin
            echo_clock   <= 1'b0;
            echo_clock_n <= 1'b1;
        end else if (ce) begin
            echo_clock   <= k_sync_q[1];
            echo_clock_n <= !k_sync_q[1];
        end
    end

    // Helper: count valid beats to check burst length
    // A stream of two bursts wraps the count back to zero
    logic [BEAT_W:0] vbeat_q;
    always_ff @(posedge clk) begin
        if (reset) begin
            vbeat_q <= '0;
        end else if (any_edge) begin
            vbeat_q <= rd_hit ? vbeat_q + 1'b1 : '0;
        end
    end

    // Checks
    a_write_start: assert property (@(posedge clk) disable iff (reset)
        wr_start |=> (wr_state_q == WR_BURST && wr_beat_q == BEAT_FIRST))
        else $error("write select not taken");

    a_write_idle: assert property (@(posedge clk) disable iff (reset)
        (wr_state_q == WR_IDLE) |-> lane_we == '0)
        else $error("write while port idle");

    a_addr_capture: assert property (@(posedge clk) disable iff (reset)
        wr_start |=> wr_addr_q == $past(addr_s1_q))
        else $error("write address not captured");

    a_read_start: assert property (@(posedge clk) disable iff (reset)
        rd_start |=> pipe_v_q[0])
        else $error("read select not taken");

    a_first_beat: assert property (@(posedge clk) disable iff (reset)
        (any_edge && pipe_v_q[RD_FIRST_POS] && !read_data_valid)
        |=> read_data_valid && !rd_data_oe_n && vbeat_q == 3'h1)
        else $error("first read beat late");

    a_kn_launch: assert property (@(posedge clk) disable iff (reset)
        (kn_rise && rd_hit) |=> read_data_valid ##1 $stable(rd_data))
        else $error("beat not launched on K#");

    a_burst_four: assert property (@(posedge clk) disable iff (reset)
        $fell(read_data_valid) |-> $past(vbeat_q) == 3'h4 || $past(vbeat_q) == 3'h0)
        else $error("read burst not four beats");

    a_float_after: assert property (@(posedge clk) disable iff (reset)
        (any_edge && !rd_hit) |=> rd_data_oe_n && !read_data_valid)
        else $error("outputs not floated");

    a_valid_aligned: assert property (@(posedge clk) disable iff (reset)
        $changed(read_data_valid) |-> $changed(echo_clock))
        else $error("valid not aligned to echo clock");

    a_echo_pair: assert property (@(posedge clk) disable iff (reset)
        ce |=> (echo_clock == $past(k_sync_q[1])) && (echo_clock_n != echo_clock))
        else $error("echo clock not following K");

    // Burst sequencing, deselect, hold and output checks
    a_beat_order: assert property (@(posedge clk) disable iff (reset)
        (wr_take && !wr_start) |=> wr_beat_q == $past(wr_beat_q) + 2'h1)
        else $error("write beat skipped");

    a_write_done: assert property (@(posedge clk) disable iff (reset)
        (wr_take && wr_beat_q == BEAT_LAST && !wr_start) |=> wr_state_q == WR_IDLE)
        else $error("write burst not closed");

    a_write_desel: assert property (@(posedge clk) disable iff (reset)
        (k_rise && wsel_sync_q[1] && wr_state_q == WR_IDLE) |=> wr_state_q == WR_IDLE)
        else $error("deselected write started");

    a_wr_addr_hold: assert property (@(posedge clk) disable iff (reset)
        !wr_start |=> $stable(wr_addr_q))
        else $error("write address moved");

    a_read_desel: assert property (@(posedge clk) disable iff (reset)
        (k_rise && rsel_sync_q[1]) |=> !pipe_v_q[0])
        else $error("deselected read started");

    a_rd_addr_hold: assert property (@(posedge clk) disable iff (reset)
        !rd_start |=> $stable(rd_addr_q[0]) && $stable(rd_addr_q[1]))
        else $error("read address moved");

    a_valid_start: assert property (@(posedge clk) disable iff (reset)
        $rose(read_data_valid) |-> $past(pipe_v_q[RD_FIRST_POS]))
        else $error("valid rose without first beat");

    a_data_on_edge: assert property (@(posedge clk) disable iff (reset)
        $changed(rd_data) |-> $past(any_edge))
        else $error("read data moved between edges");

    a_oe_valid: assert property (@(posedge clk) disable iff (reset)
        read_data_valid == !rd_data_oe_n)
        else $error("valid and drive disagree");

    // Scenarios
    c_write_burst: cover property (@(posedge clk) disable iff (reset)
        wr_take && wr_beat_q == BEAT_LAST);
    c_masked_write: cover property (@(posedge clk) disable iff (reset)
        wr_take && mask_s1_q != '0);
    c_read_burst: cover property (@(posedge clk) disable iff (reset)
        $fell(read_data_valid));
    c_back_to_back: cover property (@(posedge clk) disable iff (reset)
        rd_start && pipe_v_q[RD_FIRST_POS - 1]);
    c_same_edge: cover property (@(posedge clk) disable iff (reset)
        wr_start && rd_start);
endmodule
`default_nettype wire

/* verif/sram_ctrl_model.sv */
/*
 * Controller model: makes the K pair, drives selects, address and write beats.
 * Assumes clk runs at eight times the K rate; the bench calls issue().
 */
`timescale 1ns/100ps
`default_nettype none
module sram_ctrl_model (
    // System clock
    input  wire logic        clk,
    // Pins towards the device
    output logic             k_clk,
    output logic             k_clk_n,
    output logic             write_port_select_n,
    output logic             read_port_select_n,
    output logic [20:0]      addr,
    output logic [7:0]       wr_data,
    output logic [1:0]       write_mask_n
);
    logic [2:0]  ph = 3'h0;
    logic        req_w = 1'b0;
    logic        req_r = 1'b0;
    logic [20:0] req_a = 21'h0_0000;
    logic [31:0] req_d;
    logic [31:0] beat_d;
    logic [7:0]  req_m;
    logic [7:0]  beat_m;
    int          beat = 4;

    // Idle pin levels
    initial begin
        k_clk = 1'b1;
        k_clk_n = 1'b0;
        write_port_select_n = 1'b1;
        read_port_select_n = 1'b1;
        addr = 21'h0_0000;
        wr_data = 8'h5a;
        write_mask_n = 2'h3;
    end

    // K high on phases 0-3, K# rises at 4; pins move two clk before each edge
    always @(posedge clk) begin
        #1;
        ph = ph + 3'h1;
        k_clk = (ph < 3'h4);
        k_clk_n = ~k_clk;
        if (ph == 3'h2 || ph == 3'h6) begin
            if (beat < 4) begin
                wr_data = beat_d[beat*8 +: 8];
                write_mask_n = beat_m[beat*2 +: 2];
                beat++;
            end else begin
                wr_data = ~wr_data; // Released lines keep changing
                write_mask_n = ~write_mask_n;
            end
        end
        if (ph == 3'h2) begin
            write_port_select_n = 1'b1;
            read_port_select_n = 1'b1;
        end
        if (ph == 3'h6) begin
            write_port_select_n = ~req_w;
            read_port_select_n = ~req_r;
            addr = req_a;
            if (req_w) begin
                beat_d = req_d;
                beat_m = req_m;
                beat = 0;
            end
            req_w = 1'b0;
            req_r = 1'b0;
        end
    end

    // Queue one access for the next K rising edge
    task automatic issue(input logic w, input logic r, input logic [20:0] a, input logic [31:0] d,
                         input logic [7:0] m);
        do @(posedge clk); while (ph != 3'h5);
        req_w = w;
        req_r = r;
        req_a = a;
        req_d = d;
        req_m = m;
    endtask
endmodule
`default_nettype wire

/* verif/tb_top.sv */
/*
 * Bench for the split-port burst SRAM pin model in its x8 organisation.
 * Assumes the controller model drives all pins except clk, ce and reset.
 */
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    import sram_pins_pkg::*;
    logic        clk = 1'b0;
    logic        reset = 1'b1;
    logic        ce = 1'b1;
    logic        k_clk, k_clk_n, write_port_select_n, read_port_select_n;
    logic        rd_data_oe_n, read_data_valid, echo_clock, echo_clock_n;
    logic [20:0] addr;
    logic [7:0]  wr_data, rd_data;
    logic [1:0]  write_mask_n;
    int          n_fail = 0;
    int          comparisons = 0;

    ddr_split_port_sram_pins ddr_split_port_sram_pins_inst (
        .clk(clk), .ce(ce), .reset(reset), .k_clk(k_clk), .k_clk_n(k_clk_n),
        .write_port_select_n(write_port_select_n), .read_port_select_n(read_port_select_n),
        .addr(addr), .wr_data(wr_data),
        .write_mask_n(write_mask_n), .rd_data(rd_data), .rd_data_oe_n(rd_data_oe_n),
        .read_data_valid(read_data_valid), .echo_clock(echo_clock), .echo_clock_n(echo_clock_n));
    sram_ctrl_model sram_ctrl_model_inst (
        .clk(clk), .k_clk(k_clk), .k_clk_n(k_clk_n), .write_port_select_n(write_port_select_n),
        .read_port_select_n(read_port_select_n), .addr(addr), .wr_data(wr_data),
        .write_mask_n(write_mask_n));

    // System clock
    initial begin
        forever #20 clk = ~clk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic stop_test;
        $display("Mismatches %0d of %0d comparisons", n_fail, comparisons);
        if (n_fail == 0 && comparisons > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask

    // Wait for valid, check n beats, then the released outputs
    task automatic collect(input logic [63:0] exp, input int n, input int lat);
        int i;
        i = 0;
        while (read_data_valid !== 1'b1 && i < 60) begin
            tick(1);
            i++;
        end
        if (lat > 0) chk(i >= lat - 1 && i <= lat + 1, 1);
        for (i = 0; i < n; i++) begin
            chk({read_data_valid, rd_data_oe_n, rd_data}, {2'b10, exp[i*8 +: 8]});
            tick(4);
        end
        chk({read_data_valid, rd_data_oe_n}, 2'b01);
    endtask

    task automatic t_write_read;
        sram_ctrl_model_inst.issue(1, 0, 21'h0_0012, 32'ha1b2_c3d4, 8'h00);
        sram_ctrl_model_inst.issue(0, 0, 21'h0_0012, 32'h0000_0000, 8'h00);
        sram_ctrl_model_inst.issue(0, 1, 21'h0_0012, 32'h0000_0000, 8'h00);
        collect({32'h0, 32'ha1b2_c3d4}, 4, 26);
    endtask

    // Masked write and read of the same location on one K edge
    task automatic t_masks;
        sram_ctrl_model_inst.issue(1, 1, 21'h0_0012, 32'h0f1e_2d5b, 8'h39);
        collect({32'h0, 32'h0fb2_cd54}, 4, 26);
    endtask

    // Deselected write with toggling data leaves the location alone
    task automatic t_deselect;
        sram_ctrl_model_inst.issue(0, 0, 21'h0_0012, 32'hffff_ffff, 8'h00);
        sram_ctrl_model_inst.issue(0, 1, 21'h0_0012, 32'h0000_0000, 8'h00);
        collect({32'h0, 32'h0fb2_cd54}, 4, 26);
    endtask

    // Reads two K edges apart stream on; a read one K later is dropped
    task automatic t_back2back;
        sram_ctrl_model_inst.issue(1, 0, 21'h0_0047, 32'h7766_5544, 8'h00);
        sram_ctrl_model_inst.issue(0, 1, 21'h0_0012, 32'h0000_0000, 8'h00);
        sram_ctrl_model_inst.issue(0, 0, 21'h0_0012, 32'h0000_0000, 8'h00);
        sram_ctrl_model_inst.issue(0, 1, 21'h0_0047, 32'h0000_0000, 8'h00);
        sram_ctrl_model_inst.issue(0, 1, 21'h0_0012, 32'h0000_0000, 8'h00);
        collect({32'h7766_5544, 32'h0fb2_cd54}, 8, 0);
    endtask

    // Clock enable low freezes echo clocks and read outputs
    task automatic t_hold;
        logic [3:0] held;
        int moved;
        moved = 0;
        @(posedge clk);
        #1 ce = 1'b0;
        tick(1);
        held = {echo_clock, echo_clock_n, read_data_valid, rd_data_oe_n};
        repeat (12) begin
            tick(1);
            if ({echo_clock, echo_clock_n, read_data_valid, rd_data_oe_n} !== held) moved++;
        end
        @(posedge clk);
        #1 ce = 1'b1;
        chk(moved, 0);
        tick(4);
    endtask

    // Echo pair follows K: eight rises in 64 clk, always complementary
    task automatic t_echo;
        int rises;
        int bad;
        logic last;
        rises = 0;
        bad = 0;
        last = echo_clock;
        repeat (64) begin
            tick(1);
            if (echo_clock === 1'b1 && last === 1'b0) rises++;
            if (echo_clock_n !== ~echo_clock) bad++;
            last = echo_clock;
        end
        chk(rises, 8);
        chk(bad, 0);
    endtask

    // Main sequence
    initial begin
        tick(11);
        chk({rd_data, rd_data_oe_n, read_data_valid, echo_clock, echo_clock_n}, {8'h00, 4'h9});
        @(posedge clk);
        #1 reset = 1'b0;
        tick(4);
        t_write_read();
        t_masks();
        t_deselect();
        t_back2back();
        t_hold();
        t_echo();
        stop_test();
    end

    // Watchdog
    initial begin
        #200000;
        n_fail++;
        stop_test();
    end
endmodule
`default_nettype wire
